// ---- verilog/cwcp_regs.svh ----
`ifndef CWCP_REGS_SVH
`define CWCP_REGS_SVH

// ----------------------------------------------------------------
// configuration space and oscillator trim word addresses
// ----------------------------------------------------------------
`define CWCP_CFG_SPACE_BASE  14'h2000
`define CWCP_ID_LAST         14'h2003
`define CWCP_PART_ID_ADDR    14'h2006
`define CWCP_CFG_WORD_ADDR   14'h2007
`define CWCP_OSC_TRIM_ADDR   10'h3ff

// ----------------------------------------------------------------
// configuration word field positions
// ----------------------------------------------------------------
`define CWCP_BG_HI      13
`define CWCP_BG_LO      12
`define CWCP_UNIMP_HI   11
`define CWCP_UNIMP_LO   9
`define CWCP_CPD_BIT    8
`define CWCP_CP_BIT     7
`define CWCP_BOD_BIT    6
`define CWCP_RESET_PIN_SELECT_BIT  5
`define CWCP_PWRT_BIT   4
`define CWCP_WDT_BIT    3
`define CWCP_FOSC_HI    2
`define CWCP_FOSC_LO    0
`define CWCP_CFG_MASK   14'h31ff

// ----------------------------------------------------------------
// erased values and identification
// ----------------------------------------------------------------
`define CWCP_PM_ERASED  14'h3fff
`define CWCP_DM_ERASED  8'hff
// part and revision codes: arbitrary neutral values
`define CWCP_PART_CODE  9'h0a5
`define CWCP_REV_CODE   5'h03

// ----------------------------------------------------------------
// sweep end addresses
// ----------------------------------------------------------------
`define CWCP_PM_LAST    10'h3ff
`define CWCP_DM_LAST    10'h07f

`endif

// ---- verilog/cwcp_pkg.sv ----
package cwcp_pkg;
    // operations handed over by the serial command decoder
    typedef enum logic [2:0] {
        CWCP_OP_PM_WRITE = 3'h0,
        CWCP_OP_PM_READ  = 3'h1,
        CWCP_OP_DM_WRITE = 3'h2,
        CWCP_OP_DM_READ  = 3'h3,
        CWCP_OP_ERASE_PM = 3'h4,
        CWCP_OP_ERASE_DM = 3'h5,
        CWCP_OP_NONE     = 3'h7
    } cwcp_op_type;

    // access engine states
    typedef enum logic [0:0] {
        CWCP_IDLE  = 1'b0,
        CWCP_ERASE = 1'b1
    } cwcp_state_type;
endpackage

// ---- verilog/cwcp_osc_decode.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// clock source decode
// ----------------------------------------------------------------
module cwcp_osc_decode (
    input  wire logic [2:0] clock_source_select, // oscillator field
    output logic            osc_crystal,         // crystal amplifier on
    output logic [1:0]      osc_drive,           // 0 low power, 1 std, 2 high speed
    output logic            osc_ext_clock,       // external clock on input pin
    output logic            osc_internal,        // internal oscillator
    output logic            osc_rc,              // rc network on input pin
    output logic            osc_clkout_en,       // output pin carries clock out
    output logic            osc_in_pin_io,       // input pin free as i/o
    output logic            osc_out_pin_io       // output pin free as i/o
);
    // one row per source; the default row takes rc codes 6 and 7, so no code is unused
    always_comb begin
        osc_crystal    = 1'b0;
        osc_drive      = 2'h0;
        osc_ext_clock  = 1'b0;
        osc_internal   = 1'b0;
        osc_rc         = 1'b0;
        osc_clkout_en  = 1'b0;
        osc_in_pin_io  = 1'b0;
        osc_out_pin_io = 1'b0;
        case (clock_source_select)
            3'h0, 3'h1, 3'h2: begin
                osc_crystal = 1'b1;
                osc_drive   = clock_source_select[1:0];
            end
            3'h3: begin
                osc_ext_clock  = 1'b1;
                osc_out_pin_io = 1'b1;
            end
            3'h4, 3'h5: begin
                osc_internal   = 1'b1;
                osc_in_pin_io  = 1'b1;
                osc_clkout_en  = clock_source_select[0];
                osc_out_pin_io = ~clock_source_select[0];
            end
            default: begin
                osc_rc         = 1'b1;
                osc_clkout_en  = clock_source_select[0];
                osc_out_pin_io = ~clock_source_select[0];
            end
        endcase
    end
endmodule // cwcp_osc_decode

// ---- verilog/cwcp_core.sv ----
// Functional notes
// - programmed bit reads 0, erased reads 1
// - bits 11 to 9 always read 0
// - bandgap trim code drives reference monotonically
// - data protect low blocks data reads
// - code protect low protects program memory
// - bit 6 enables brown-out reset
// - power-up timer runs only when bit4 low
// - bit 5 selects reset pin function
// - bit 3 enables the watchdog
// - oscillator field selects source and pins
// - read-only part id word at 2006h
// - protected program reads zero except 3FFh
// - protected program memory refuses writes
// - id and config writes accepted even under code protection
// - bulk erase also clears protected data
// - configuration word lives at 2007h
`timescale 1ns/1ps
`include "cwcp_regs.svh"

module cwcp_core (
    input  wire logic                 clock,              // 10 mhz system clock
    input  wire logic                 srst,               // sync reset, high
    input  wire logic                 op_valid,           // one-cycle op strobe
    input  wire cwcp_pkg::cwcp_op_type op_code,           // operation
    input  wire logic [13:0]          op_addr,            // word address
    input  wire logic [13:0]          op_wdata,           // write data
    output logic                      busy,               // erase sweep running
    output logic                      rd_valid,           // read answer pulse
    output logic [13:0]               rd_data,            // read answer word
    output logic [1:0]                bandgap_trim,       // reference trim
    output logic                      program_protected,  // code protection on
    output logic                      data_protected,     // data read blocked
    output logic                      brownout_reset_en,  // brown-out reset on
    output logic                      master_reset_pin_en,// pin is master reset
    output logic                      powerup_timer_run,  // power-up timer on
    output logic                      watchdog_en,        // watchdog on
    output logic                      osc_crystal,        // crystal amplifier on
    output logic [1:0]                osc_drive,          // crystal drive level
    output logic                      osc_ext_clock,      // external clock
    output logic                      osc_internal,       // internal oscillator
    output logic                      osc_rc,             // rc oscillator
    output logic                      osc_clkout_en,      // clock out on pin
    output logic                      osc_in_pin_io,      // input pin is i/o
    output logic                      osc_out_pin_io      // output pin is i/o
);
    import cwcp_pkg::*;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // nonvolatile cells: no reset, they only change by program or erase
    logic [13:0]    pm_mem [0:1023];     // program memory
    logic [7:0]     dm_mem [0:127];      // data memory
    logic [13:0]    id_mem [0:3];        // id locations
    logic [13:0]    stored_cfg;          // configuration cell
    logic [13:0]    act_cfg;             // copy steering the device
    logic [13:0]    next_act_cfg;        // next active copy

    // ----------------------------------------------------------------
    // engine state
    // ----------------------------------------------------------------
    cwcp_state_type state;               // idle or erasing
    cwcp_state_type next_state;          // next state
    logic [9:0]     sweep;               // erase address
    logic [9:0]     next_sweep;          // next erase address
    logic           erase_pm;            // sweep clears program words
    logic           next_erase_pm;       // next value
    logic           erase_dm;            // sweep clears data bytes
    logic           next_erase_dm;       // next value
    logic           erase_cfg;           // pending id and config wipe
    logic           next_erase_cfg;      // next value
    logic           next_rd_valid;       // next answer strobe
    logic [13:0]    next_rd_data;        // next answer word

    // ----------------------------------------------------------------
    // decode of the incoming op
    // ----------------------------------------------------------------
    logic           take;                // op accepted
    logic           in_cfg;              // address in configuration space
    logic           pm_we;               // program word write enable
    logic           dm_we;               // data byte write enable
    logic           id_we;               // id word write enable
    logic           cfg_we;              // configuration write enable
    logic           cp_on;               // code protection active
    logic           cpd_on;              // data protection active

    // ops arriving during an erase sweep are dropped
    assign take   = op_valid && (state == CWCP_IDLE);
    assign in_cfg = op_addr >= `CWCP_CFG_SPACE_BASE;
    assign cp_on  = ~act_cfg[`CWCP_CP_BIT];
    assign cpd_on = ~act_cfg[`CWCP_CPD_BIT];

    assign pm_we  = take && (op_code == CWCP_OP_PM_WRITE) && !in_cfg && !cp_on;
    assign id_we  = take && (op_code == CWCP_OP_PM_WRITE) && in_cfg
                    && (op_addr <= `CWCP_ID_LAST);
    assign cfg_we = take && (op_code == CWCP_OP_PM_WRITE)
                    && (op_addr == `CWCP_CFG_WORD_ADDR);
    // data writes stay open; protection guards reads and blocks a data-only erase
    assign dm_we  = take && (op_code == CWCP_OP_DM_WRITE);

    // ----------------------------------------------------------------
    // read path and erase sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_sweep     = sweep;
        next_erase_pm  = erase_pm;
        next_erase_dm  = erase_dm;
        next_erase_cfg = 1'b0;
        next_rd_valid  = 1'b0;
        next_rd_data   = rd_data;
        case (state)
            CWCP_IDLE: begin
                if (take) begin
                    case (op_code)
                        CWCP_OP_PM_READ: begin
                            next_rd_valid = 1'b1;
                            if (!in_cfg) begin
                                if (cp_on && (op_addr[9:0] != `CWCP_OSC_TRIM_ADDR)) begin
                                    next_rd_data = 14'h0000;
                                end else begin
                                    next_rd_data = pm_mem[op_addr[9:0]];
                                end
                            end else if (op_addr <= `CWCP_ID_LAST) begin
                                next_rd_data = id_mem[op_addr[1:0]];
                            end else if (op_addr == `CWCP_PART_ID_ADDR) begin
                                next_rd_data = {`CWCP_PART_CODE, `CWCP_REV_CODE};
                            end else if (op_addr == `CWCP_CFG_WORD_ADDR) begin
                                next_rd_data = stored_cfg & `CWCP_CFG_MASK;
                            end else begin
                                // reserved locations answer zero
                                next_rd_data = 14'h0000;
                            end
                        end
                        CWCP_OP_DM_READ: begin
                            next_rd_valid = 1'b1;
                            if (cpd_on) begin
                                next_rd_data = 14'h0000;
                            end else begin
                                next_rd_data = {6'h00, dm_mem[op_addr[6:0]]};
                            end
                        end
                        CWCP_OP_ERASE_PM: begin
                            next_state     = CWCP_ERASE;
                            next_sweep     = 10'h000;
                            next_erase_pm  = 1'b1;
                            next_erase_dm  = cpd_on;
                            next_erase_cfg = in_cfg;
                        end
                        CWCP_OP_ERASE_DM: begin
                            // a protected data array will not erase alone
                            if (!cpd_on) begin
                                next_state    = CWCP_ERASE;
                                next_sweep    = 10'h000;
                                next_erase_pm = 1'b0;
                                next_erase_dm = 1'b1;
                            end
                        end
                        default: begin
                            next_state = CWCP_IDLE;
                        end
                    endcase
                end
            end
            CWCP_ERASE: begin
                // one word per cycle keeps the arrays single ported
                if ((erase_pm && sweep == `CWCP_PM_LAST)
                    || (!erase_pm && sweep == `CWCP_DM_LAST)) begin
                    next_state    = CWCP_IDLE;
                    next_erase_pm = 1'b0;
                    next_erase_dm = 1'b0;
                end else begin
                    next_sweep = sweep + 10'h001;
                end
            end
            default: begin
                next_state = CWCP_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // active configuration copy
    // ----------------------------------------------------------------
    // new settings only act after the next reset
    always_comb begin
        next_act_cfg = act_cfg;
        if (srst) begin
            next_act_cfg = stored_cfg & `CWCP_CFG_MASK;
        end
    end

    // engine and answer registers
    always_ff @(posedge clock) begin
        if (srst) begin
            state     <= CWCP_IDLE;
            sweep     <= 10'h000;
            erase_pm  <= 1'b0;
            erase_dm  <= 1'b0;
            erase_cfg <= 1'b0;
            rd_valid  <= 1'b0;
            rd_data   <= 14'h0000;
        end else begin
            state     <= next_state;
            sweep     <= next_sweep;
            erase_pm  <= next_erase_pm;
            erase_dm  <= next_erase_dm;
            erase_cfg <= next_erase_cfg;
            rd_valid  <= next_rd_valid;
            rd_data   <= next_rd_data;
        end
        act_cfg <= next_act_cfg;
    end

    // ----------------------------------------------------------------
    // nonvolatile arrays
    // ----------------------------------------------------------------
    // erased cells read as ones
    always_ff @(posedge clock) begin
        if (pm_we) begin
            pm_mem[op_addr[9:0]] <= op_wdata;
        end
        if (dm_we) begin
            dm_mem[op_addr[6:0]] <= op_wdata[7:0];
        end
        if (state == CWCP_ERASE && erase_pm) begin
            pm_mem[sweep] <= `CWCP_PM_ERASED;
        end
        if (state == CWCP_ERASE && erase_dm && sweep <= `CWCP_DM_LAST) begin
            dm_mem[sweep[6:0]] <= `CWCP_DM_ERASED;
        end
    end

    // ids and config wiped one cycle after a config-space erase
    always_ff @(posedge clock) begin
        if (id_we) begin
            id_mem[op_addr[1:0]] <= op_wdata;
        end
        if (cfg_we) begin
            stored_cfg <= op_wdata & `CWCP_CFG_MASK;
        end
        if (erase_cfg) begin
            for (int i = 0; i < 4; i++) begin
                id_mem[i] <= `CWCP_PM_ERASED;
            end
            stored_cfg <= `CWCP_CFG_MASK;
        end
    end

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    assign busy              = (state == CWCP_ERASE);
    // code passed straight to trim dac
    assign bandgap_trim      = act_cfg[`CWCP_BG_HI:`CWCP_BG_LO];
    assign program_protected = cp_on;
    assign data_protected    = cpd_on;
    assign brownout_reset_en = act_cfg[`CWCP_BOD_BIT];
    assign master_reset_pin_en = act_cfg[`CWCP_RESET_PIN_SELECT_BIT];
    assign powerup_timer_run = ~act_cfg[`CWCP_PWRT_BIT];
    assign watchdog_en       = act_cfg[`CWCP_WDT_BIT];

    cwcp_osc_decode u_osc (
        .clock_source_select (act_cfg[`CWCP_FOSC_HI:`CWCP_FOSC_LO]),
        .osc_crystal         (osc_crystal),
        .osc_drive           (osc_drive),
        .osc_ext_clock       (osc_ext_clock),
        .osc_internal        (osc_internal),
        .osc_rc              (osc_rc),
        .osc_clkout_en       (osc_clkout_en),
        .osc_in_pin_io       (osc_in_pin_io),
        .osc_out_pin_io      (osc_out_pin_io)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_unimp_bits_zero: assert property (@(posedge clock) disable iff (srst)
        take && op_code == CWCP_OP_PM_READ && op_addr == `CWCP_CFG_WORD_ADDR
        |=> rd_valid && rd_data[11:9] == 3'h0)
        else $error("unimplemented config bits not zero");
    a_prot_read_mask: assert property (@(posedge clock) disable iff (srst)
        take && op_code == CWCP_OP_PM_READ && !in_cfg && cp_on
        && op_addr[9:0] != `CWCP_OSC_TRIM_ADDR |=> rd_data == 14'h0000)
        else $error("protected program read not masked");
    a_data_read_block: assert property (@(posedge clock) disable iff (srst)
        take && op_code == CWCP_OP_DM_READ && cpd_on |=> rd_data == 14'h0000)
        else $error("protected data read not masked");
    a_prot_write_refuse: assert property (@(posedge clock) disable iff (srst)
        take && op_code == CWCP_OP_PM_WRITE && !in_cfg && cp_on
        |=> pm_mem[$past(op_addr[9:0])] == $past(pm_mem[op_addr[9:0]]))
        else $error("protected program write accepted");
    a_cfg_write_take: assert property (@(posedge clock) disable iff (srst)
        cfg_we && cp_on |=> stored_cfg == ($past(op_wdata) & `CWCP_CFG_MASK))
        else $error("config write lost under protection");
    a_cfg_reset_latch: assert property (@(posedge clock)
        srst |=> act_cfg === ($past(stored_cfg) & `CWCP_CFG_MASK))
        else $error("config not latched on reset");
    a_part_id_read: assert property (@(posedge clock) disable iff (srst)
        take && op_code == CWCP_OP_PM_READ && op_addr == `CWCP_PART_ID_ADDR
        |=> rd_data == {`CWCP_PART_CODE, `CWCP_REV_CODE})
        else $error("part id word wrong");
    a_pwrt_bod_apart: assert property (@(posedge clock) disable iff (srst)
        act_cfg[`CWCP_PWRT_BIT] && brownout_reset_en |-> !powerup_timer_run)
        else $error("power-up timer follows brown-out enable");
    a_erase_data_too: assert property (@(posedge clock) disable iff (srst)
        take && op_code == CWCP_OP_ERASE_PM && cpd_on |=> (busy && erase_dm) [*8])
        else $error("protected data not erased with program");

    c_prot_read: cover property (@(posedge clock) take && op_code == CWCP_OP_PM_READ && cp_on);
    c_erase_all: cover property (@(posedge clock) busy && erase_pm && erase_dm);
    c_cfg_write: cover property (@(posedge clock) cfg_we);
endmodule // cwcp_core

// ---- bench/cwcp_prog_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// programmer model: drives each op just after a rising edge
// ----------------------------------------------------------------
module cwcp_prog_model (
    input  wire logic                  clock,    // system clock
    input  wire logic                  busy,     // erase sweep running
    input  wire logic                  rd_valid, // read answer pulse
    input  wire logic [13:0]           rd_data,  // read answer word
    output logic                       srst,     // sync reset
    output logic                       op_valid, // op strobe
    output cwcp_pkg::cwcp_op_type      op_code,  // operation
    output logic [13:0]                op_addr,  // word address
    output logic [13:0]                op_wdata  // write data
);
    import cwcp_pkg::*;
    // idle levels at time zero
    initial begin
        srst = 1'b1;
        op_valid = 1'b0;
        op_code = CWCP_OP_NONE;
        op_addr = 14'h0000;
        op_wdata = 14'h0000;
    end
    // one op; released lines show inverted junk, not a held value
    task automatic op(input cwcp_op_type c, input logic [13:0] a, input logic [13:0] d);
        // an idle edge first, so back-to-back ops never re-raise the strobe in one step
        @(posedge clock);
        #1;
        op_valid = 1'b1;
        op_code = c;
        op_addr = a;
        op_wdata = d;
        @(posedge clock);
        #1;
        op_valid = 1'b0;
        op_code = CWCP_OP_NONE;
        op_addr = ~a;
        op_wdata = ~d;
    endtask
    // read: answer stands for one cycle after the taking edge
    task automatic rd(input cwcp_op_type c, input logic [13:0] a, output logic [13:0] q);
        op(c, a, 14'h0000);
        q = (rd_valid === 1'b1) ? rd_data : 14'hxxxx;
    endtask
    // erase, then count busy cycles under a bound
    task automatic erase(input cwcp_op_type c, input logic [13:0] a, output int n);
        op(c, a, 14'h0000);
        for (n = 0; busy === 1'b1 && n < 1100; n++) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic rst(input int k);
        srst = 1'b1;
        repeat (k) @(posedge clock);
        #1;
        srst = 1'b0;
    endtask
    // protection removal; erase wipes the trims, so they travel through here
    task automatic unprotect(output int n);
        logic [13:0] trim;
        logic [13:0] cfg;
        int m;
        rd(CWCP_OP_PM_READ, 14'h03ff, trim);
        rd(CWCP_OP_PM_READ, 14'h2007, cfg);
        erase(CWCP_OP_ERASE_PM, 14'h2000, n);
        erase(CWCP_OP_ERASE_DM, 14'h2000, m);
        rst(1);
        op(CWCP_OP_PM_WRITE, 14'h03ff, trim);
        op(CWCP_OP_PM_WRITE, 14'h2007, {cfg[13:12], 12'hfff});
    endtask
    // checksum; carries past 16 bits simply fall off
    task automatic checksum(input logic prot, output logic [15:0] s);
        logic [13:0] q;
        rd(CWCP_OP_PM_READ, 14'h2007, q);
        s = {7'h00, q[8:0]};
        if (prot) begin
            // protected: id nibbles, first id most significant
            for (int i = 0; i < 4; i++) begin
                rd(CWCP_OP_PM_READ, 14'h2000 + 14'(i), q);
                s = s + (16'(q[3:0]) << (12 - 4 * i));
            end
        end else begin
            // open part: every program word below the trim word
            for (int i = 0; i < 1023; i++) begin
                rd(CWCP_OP_PM_READ, 14'(i), q);
                s = s + {2'h0, q};
            end
        end
    endtask
    // image byte: logical 2100h onward maps to data byte 0 onward
    task automatic img_byte(input logic [15:0] la, input logic [7:0] b);
        logic [15:0] off;
        off = la - 16'h2100;
        op(CWCP_OP_DM_WRITE, off[13:0], {6'h00, b});
    endtask
endmodule // cwcp_prog_model

// ---- bench/cwcp_tb_top.sv ----
`timescale 1ns/1ps
module cwcp_tb_top;
    import cwcp_pkg::*;
    logic clock, srst, op_valid, busy, rd_valid, program_protected, data_protected;
    logic brownout_reset_en, master_reset_pin_en, powerup_timer_run, watchdog_en;
    logic osc_crystal, osc_ext_clock, osc_internal, osc_rc, osc_clkout_en;
    logic osc_in_pin_io, osc_out_pin_io;
    logic [1:0] bandgap_trim, osc_drive;
    logic [13:0] op_addr, op_wdata, rd_data, p, c;
    logic [15:0] s;
    cwcp_op_type op_code;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    cwcp_core cwcp_core_inst (.*);
    cwcp_prog_model cwcp_prog_model_inst (.*);
    // 100 ns clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input cwcp_op_type k, input logic [13:0] a, input logic [13:0] e);
        logic [13:0] q;
        cwcp_prog_model_inst.rd(k, a, q);
        chk(q, e);
    endtask
    task automatic wr(input cwcp_op_type k, input logic [13:0] a, input logic [13:0] d);
        cwcp_prog_model_inst.op(k, a, d);
    endtask
    // control levels and clock decode expected from a config word
    task automatic ctl(input logic [13:0] w);
        logic [2:0] f;
        f = w[2:0];
        chk({6'h00, bandgap_trim, program_protected, data_protected, brownout_reset_en,
             master_reset_pin_en, powerup_timer_run, watchdog_en},
            {6'h00, w[13:12], ~w[7], ~w[8], w[6], w[5], ~w[4], w[3]});
        chk({5'h00, osc_crystal, osc_ext_clock, osc_internal, osc_rc, osc_clkout_en,
             osc_in_pin_io, osc_out_pin_io, (f < 3'h3) ? osc_drive : 2'h0},
            {5'h00, f < 3'h3, f == 3'h3, f[2:1] == 2'h2, f[2:1] == 2'h3, f[2] & f[0],
             f[2:1] == 2'h2, f == 3'h3 || f == 3'h4 || f == 3'h6, (f < 3'h3) ? f[1:0] : 2'h0});
    endtask
    task automatic complete_run;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog: the run needs about 4400 cycles
    initial begin
        #1000000;
        error_cnt++;
        complete_run;
    end
    initial begin
        cwcp_prog_model_inst.rst(3);
        cwcp_prog_model_inst.erase(CWCP_OP_ERASE_PM, 14'h2000, n);
        cwcp_prog_model_inst.rst(1);
        rc(CWCP_OP_PM_READ, 14'h2007, 14'h31ff);
        wr(CWCP_OP_PM_WRITE, 14'h2006, 14'h0000);
        rc(CWCP_OP_PM_READ, 14'h2006, 14'h14a3);
        p = 14'h31ff;
        $display("test blank done");
        // every clock source and trim code; new word acts only after reset
        for (int f = 0; f < 16; f++) begin
            c = {f[1:0], 5'h1f, f[3:0], f[2:0]};
            wr(CWCP_OP_PM_WRITE, 14'h2007, c);
            rc(CWCP_OP_PM_READ, 14'h2007, c & 14'h31ff);
            ctl(p);
            cwcp_prog_model_inst.rst(1);
            ctl(c);
            p = c;
        end
        $display("test fields done");
        wr(CWCP_OP_PM_WRITE, 14'h0010, 14'h1234);
        wr(CWCP_OP_PM_WRITE, 14'h03ff, 14'h0abc);
        cwcp_prog_model_inst.img_byte(16'h2105, 8'h5a);
        rc(CWCP_OP_DM_READ, 14'h0005, 14'h005a);
        wr(CWCP_OP_PM_WRITE, 14'h2007, 14'h1e4d);
        cwcp_prog_model_inst.rst(1);
        ctl(14'h1e4d);
        rc(CWCP_OP_PM_READ, 14'h0010, 14'h0000);
        rc(CWCP_OP_PM_READ, 14'h03ff, 14'h0abc);
        rc(CWCP_OP_PM_READ, 14'h2007, 14'h104d);
        wr(CWCP_OP_PM_WRITE, 14'h2000, 14'h0012);
        rc(CWCP_OP_PM_READ, 14'h2000, 14'h0012);
        wr(CWCP_OP_PM_WRITE, 14'h03ff, 14'h0555);
        rc(CWCP_OP_PM_READ, 14'h03ff, 14'h0abc);
        wr(CWCP_OP_PM_WRITE, 14'h2007, 14'h1e4c);
        rc(CWCP_OP_PM_READ, 14'h2007, 14'h104c);
        cwcp_prog_model_inst.checksum(1'b1, s);
        chk({6'h00, s[15:8]}, 14'h0030);
        chk({6'h00, s[7:0]}, 14'h004b);
        rc(CWCP_OP_DM_READ, 14'h0005, 14'h0000);
        $display("test protect done");
        cwcp_prog_model_inst.unprotect(n);
        chk(n[13:0], 14'h0400);
        cwcp_prog_model_inst.rst(1);
        rc(CWCP_OP_PM_READ, 14'h2007, 14'h11ff);
        rc(CWCP_OP_PM_READ, 14'h03ff, 14'h0abc);
        rc(CWCP_OP_PM_READ, 14'h0010, 14'h3fff);
        rc(CWCP_OP_DM_READ, 14'h0005, 14'h00ff);
        ctl(14'h11ff);
        cwcp_prog_model_inst.checksum(1'b0, s);
        chk({6'h00, s[15:8]}, 14'h00be);
        chk({6'h00, s[7:0]}, 14'h0000);
        wr(CWCP_OP_DM_WRITE, 14'h0005, 14'h005a);
        cwcp_prog_model_inst.erase(CWCP_OP_ERASE_DM, 14'h0000, n);
        chk(n[13:0], 14'h0080);
        rc(CWCP_OP_DM_READ, 14'h0005, 14'h00ff);
        $display("test unprotect done");
        complete_run;
    end
endmodule // cwcp_tb_top
